/* src/hsic_filt_pkg.sv */
// Purpose: constants and types shared by the bus-state qualification logic
// Assumes: 100 MHz system clock, qualification units of one 60 MHz period
// Notes:   register indices are the printed offsets; byte address is four times
package hsic_filt_pkg;

  // clock rates and the derived reference tick
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned REF_MHZ       = 60;
  localparam int          ACC_W         = 8;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(REF_MHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_MHZ);

  // apb geometry
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int INDEX_W = 10;

  // register indices (byte address = index * 4)
  localparam logic [INDEX_W-1:0] IDX_RESET_LO  = 10'h214;
  localparam logic [INDEX_W-1:0] IDX_RESET_HI  = 10'h215;
  localparam logic [INDEX_W-1:0] IDX_RESUME_LO = 10'h218;
  localparam logic [INDEX_W-1:0] IDX_RESUME_HI = 10'h219;
  localparam logic [INDEX_W-1:0] IDX_IDLE_B0   = 10'h21c;
  localparam logic [INDEX_W-1:0] IDX_IDLE_B1   = 10'h21d;
  localparam logic [INDEX_W-1:0] IDX_IDLE_B2   = 10'h21e;
  localparam logic [INDEX_W-1:0] IDX_STATUS    = 10'h220;

  // reset values
  localparam logic [7:0] RST_RESET_LO  = 8'hb4;
  localparam logic [7:0] RST_RESET_HI  = 8'h00;
  localparam logic [7:0] RST_RESUME_LO = 8'hb4;
  localparam logic [7:0] RST_RESUME_HI = 8'h00;
  localparam logic [7:0] RST_IDLE_B0   = 8'h60;
  localparam logic [7:0] RST_IDLE_B1   = 8'hea;
  localparam logic [3:0] RST_IDLE_TOP  = 4'h0;

  // field layout
  localparam int FILT_W       = 16;
  localparam int IDLE_W       = 20;
  localparam int IDLE_TOP_LSB = 4;
  localparam int STAT_LINE_LSB = 4;

  // link phase
  typedef enum logic [3:0] {
    st_active  = 4'b0001,
    st_reset   = 4'b0010,
    st_suspend = 4'b0100,
    st_wake    = 4'b1000
  } link_state_t;

  // decoded hsic line state {strobe, data}
  typedef enum logic [1:0] {
    line_reset  = 2'b00,
    line_resume = 2'b01,
    line_idle   = 2'b10,
    line_other  = 2'b11
  } line_state_t;

endpackage : hsic_filt_pkg

/* src/qual_timer.sv */
// Purpose: counts reference ticks while a bus state holds, pulses once at the limit
// Assumes: tick is a one-cycle enable at the reference rate
// Notes:   a limit of zero qualifies on the first tick
`timescale 1ns/1ps
module qual_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic         active,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  logic [W:0] count_r;
  logic [W:0] count_inc;
  logic       fired_r;
  logic       hit;

  assign count_inc = count_r + (W+1)'(1);
  assign hit       = active & tick & ~fired_r & (count_inc >= {1'b0, limit});

  always_ff @(posedge clk) begin
    if (rst || !active) begin
      count_r <= '0;
      fired_r <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= hit;
      if (hit) begin
        fired_r <= 1'b1;
      end
      if (tick && !fired_r) begin
        count_r <= count_inc;
      end
    end
  end

endmodule : qual_timer

/* src/hsic_bus_state_filters.sv */
// Purpose: qualifies hsic reset, host resume and idle bus states against timers
// Assumes: apb slave, zero wait states; hsic pins are asynchronous to clk
// Notes:   one-cycle resume and resuspend pulses, reset valid is a level; link phase reported on link_state
// Function
// - reset state valid only after held for the 16-bit reset time.
// - reset qualification applies only when entering the reset state.
// - host resume qualified by 16-bit resume time; not for device wake.
// - idle time is 20 bits over three bytes, top nibble upper.
// - idle check runs only after wake from suspend with stable clock.
// - idle held for full idle time after wake returns to suspend.
// - all qualification times count 60 MHz reference periods.
// - each 16-bit time is a low and high byte, both read/write.
// - reset time low byte is its own register, reset value nonzero.
`timescale 1ns/1ps
module hsic_bus_state_filters (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [hsic_filt_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [hsic_filt_pkg::DATA_W-1:0]  pwdata,
  output logic      [hsic_filt_pkg::DATA_W-1:0]  prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              hsic_strobe,
  input  wire logic                              hsic_data,
  input  wire logic                              suspend_enter,
  input  wire logic                              clk_stable,
  input  wire logic                              remote_wake_active,
  output logic                                   bus_reset_valid,
  output logic                                   host_resume_pulse,
  output logic                                   resuspend_pulse,
  output logic      [3:0]                        link_state
);
  import hsic_filt_pkg::*;

  // software-visible filter times
  logic [7:0] reset_qual_time_lo_r;
  logic [7:0] reset_qual_time_hi_r;
  logic [7:0] resume_qual_time_lo_r;
  logic [7:0] resume_qual_time_hi_r;
  logic [7:0] idle_qual_time_b0_r;
  logic [7:0] idle_qual_time_b1_r;
  logic [3:0] idle_qual_time_top_r;

  // pin synchronisers
  logic        strobe_meta_r;
  logic        strobe_sync_r;
  logic        data_meta_r;
  logic        data_sync_r;
  logic        strobe_prev_r;
  logic        strobe_edge;
  line_state_t line_now;
  line_state_t line_prev_r;
  logic        line_changed;

  // reference tick
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_sum;
  logic             ref_tick;

  // link phase machine
  link_state_t state_r;
  link_state_t state_nxt;

  // timer hookup
  logic [FILT_W-1:0] reset_qualify_time;
  logic [FILT_W-1:0] resume_qualify_time;
  logic [IDLE_W-1:0] idle_qualify_time;
  logic              reset_arm;
  logic              resume_arm;
  logic              idle_arm;
  logic              reset_done;
  logic              resume_done;
  logic              idle_done;

  // apb decode
  logic [INDEX_W-1:0] index;
  logic               sel_reset_lo;
  logic               sel_reset_hi;
  logic               sel_resume_lo;
  logic               sel_resume_hi;
  logic               sel_idle_b0;
  logic               sel_idle_b1;
  logic               sel_idle_b2;
  logic               sel_status;
  logic               mapped;
  logic               upper_ok;
  logic               setup_phase;
  logic               wr_en;
  logic [7:0]         wbyte;
  logic [DATA_W-1:0]  rd_mux;
  logic [DATA_W-1:0]  status_word;

  // first flops feed only the second flops
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_meta_r <= 1'b1;
      strobe_sync_r <= 1'b1;
      data_meta_r   <= 1'b0;
      data_sync_r   <= 1'b0;
    end else begin
      strobe_meta_r <= hsic_strobe;
      strobe_sync_r <= strobe_meta_r;
      data_meta_r   <= hsic_data;
      data_sync_r   <= data_meta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_prev_r <= 1'b1;
      line_prev_r   <= line_idle;
    end else begin
      strobe_prev_r <= strobe_sync_r;
      line_prev_r   <= line_now;
    end
  end

  assign line_now     = line_state_t'({strobe_sync_r, data_sync_r});
  assign strobe_edge  = strobe_sync_r ^ strobe_prev_r;
  assign line_changed = (line_now != line_prev_r) | strobe_edge;

  assign acc_sum  = acc_r + ACC_STEP;
  assign ref_tick = (acc_sum >= ACC_WRAP);

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= '0;
    end else if (ref_tick) begin
      acc_r <= acc_sum - ACC_WRAP;
    end else begin
      acc_r <= acc_sum;
    end
  end

  assign reset_qualify_time  = {reset_qual_time_hi_r, reset_qual_time_lo_r};
  assign resume_qualify_time = {resume_qual_time_hi_r, resume_qual_time_lo_r};
  assign idle_qualify_time   = {idle_qual_time_top_r, idle_qual_time_b1_r,
                                idle_qual_time_b0_r};

  assign reset_arm  = (line_now == line_reset) & ~line_changed & (state_r != st_reset);
  assign resume_arm = (line_now == line_resume) & ~line_changed & ~remote_wake_active &
                      ((state_r == st_suspend) | (state_r == st_wake));
  assign idle_arm   = (line_now == line_idle) & ~line_changed & (state_r == st_wake);

  qual_timer #(.W(FILT_W)) u_reset_timer (
    .clk    (clk),
    .rst    (rst),
    .tick   (ref_tick),
    .active (reset_arm),
    .limit  (reset_qualify_time),
    .done   (reset_done)
  );

  qual_timer #(.W(FILT_W)) u_resume_timer (
    .clk    (clk),
    .rst    (rst),
    .tick   (ref_tick),
    .active (resume_arm),
    .limit  (resume_qualify_time),
    .done   (resume_done)
  );

  qual_timer #(.W(IDLE_W)) u_idle_timer (
    .clk    (clk),
    .rst    (rst),
    .tick   (ref_tick),
    .active (idle_arm),
    .limit  (idle_qualify_time),
    .done   (idle_done)
  );

  // timer results only count while still armed, so a late pulse is dropped
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_active: begin
        if (reset_done && reset_arm) begin
          state_nxt = st_reset;
        end else if (suspend_enter) begin
          state_nxt = st_suspend;
        end
      end
      st_reset: begin
        if (line_now != line_reset) begin
          state_nxt = st_active;
        end
      end
      st_suspend: begin
        if (reset_done && reset_arm) begin
          state_nxt = st_reset;
        end else if (resume_done && resume_arm) begin
          state_nxt = st_active;
        end else if (clk_stable) begin
          state_nxt = st_wake;
        end
      end
      st_wake: begin
        if (reset_done && reset_arm) begin
          state_nxt = st_reset;
        end else if (resume_done && resume_arm) begin
          state_nxt = st_active;
        end else if (idle_done && idle_arm) begin
          state_nxt = st_suspend;
        end
      end
      default: state_nxt = st_active;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r           <= st_active;
      host_resume_pulse <= 1'b0;
      resuspend_pulse   <= 1'b0;
    end else begin
      state_r           <= state_nxt;
      host_resume_pulse <= resume_done & resume_arm & (state_r != st_active) &
                           ~(reset_done & reset_arm);
      resuspend_pulse   <= (state_r == st_wake) & (state_nxt == st_suspend);
    end
  end

  assign bus_reset_valid = (state_r == st_reset);
  assign link_state      = state_r;

  // apb slave: zero wait states, read data captured in the setup cycle
  assign index         = paddr[ADDR_W-1:2];
  assign upper_ok      = (paddr[1:0] == 2'b00);
  assign sel_reset_lo  = upper_ok & (index == IDX_RESET_LO);
  assign sel_reset_hi  = upper_ok & (index == IDX_RESET_HI);
  assign sel_resume_lo = upper_ok & (index == IDX_RESUME_LO);
  assign sel_resume_hi = upper_ok & (index == IDX_RESUME_HI);
  assign sel_idle_b0   = upper_ok & (index == IDX_IDLE_B0);
  assign sel_idle_b1   = upper_ok & (index == IDX_IDLE_B1);
  assign sel_idle_b2   = upper_ok & (index == IDX_IDLE_B2);
  assign sel_status    = upper_ok & (index == IDX_STATUS);
  assign mapped        = sel_reset_lo | sel_reset_hi | sel_resume_lo | sel_resume_hi |
                         sel_idle_b0 | sel_idle_b1 | sel_idle_b2 | sel_status;
  assign setup_phase   = psel & ~penable;
  // status is read-only, so a write there is an error too
  assign wr_en         = psel & penable & pwrite & mapped & ~sel_status;
  assign wbyte         = pwdata[7:0];
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & (~mapped | (pwrite & sel_status));

  assign status_word = {{(DATA_W-6){1'b0}}, line_now, state_r};

  assign rd_mux =
      sel_reset_lo  ? {{(DATA_W-8){1'b0}}, reset_qual_time_lo_r}  :
      sel_reset_hi  ? {{(DATA_W-8){1'b0}}, reset_qual_time_hi_r}  :
      sel_resume_lo ? {{(DATA_W-8){1'b0}}, resume_qual_time_lo_r} :
      sel_resume_hi ? {{(DATA_W-8){1'b0}}, resume_qual_time_hi_r} :
      sel_idle_b0   ? {{(DATA_W-8){1'b0}}, idle_qual_time_b0_r}   :
      sel_idle_b1   ? {{(DATA_W-8){1'b0}}, idle_qual_time_b1_r}   :
      sel_idle_b2   ? {{(DATA_W-8){1'b0}}, idle_qual_time_top_r, 4'h0} :
      sel_status    ? status_word : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_qual_time_lo_r <= RST_RESET_LO;
    end else if (wr_en && sel_reset_lo) begin
      reset_qual_time_lo_r <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_qual_time_hi_r  <= RST_RESET_HI;
      resume_qual_time_lo_r <= RST_RESUME_LO;
      resume_qual_time_hi_r <= RST_RESUME_HI;
    end else if (wr_en) begin
      if (sel_reset_hi) begin
        reset_qual_time_hi_r <= wbyte;
      end
      if (sel_resume_lo) begin
        resume_qual_time_lo_r <= wbyte;
      end
      if (sel_resume_hi) begin
        resume_qual_time_hi_r <= wbyte;
      end
    end
  end

  // idle bytes, top nibble from bits 7:4
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_qual_time_b0_r  <= RST_IDLE_B0;
      idle_qual_time_b1_r  <= RST_IDLE_B1;
      idle_qual_time_top_r <= RST_IDLE_TOP;
    end else if (wr_en) begin
      if (sel_idle_b0) begin
        idle_qual_time_b0_r <= wbyte;
      end
      if (sel_idle_b1) begin
        idle_qual_time_b1_r <= wbyte;
      end
      if (sel_idle_b2) begin
        idle_qual_time_top_r <= wbyte[7:IDLE_TOP_LSB];
      end
    end
  end

endmodule : hsic_bus_state_filters

/* dv/hsic_filt_assertions.sv */
// Purpose: concurrent checks on the bus-state qualifier ports
// Assumes: host holds each line state for many clk cycles
// Notes:   bound to the design from tb_top
`timescale 1ns/1ps
module hsic_filt_assertions (
  input wire logic                             clk,
  input wire logic                             rst,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [hsic_filt_pkg::ADDR_W-1:0] paddr,
  input wire logic [hsic_filt_pkg::DATA_W-1:0] pwdata,
  input wire logic [hsic_filt_pkg::DATA_W-1:0] prdata,
  input wire logic                             pready,
  input wire logic                             pslverr,
  input wire logic                             hsic_strobe,
  input wire logic                             hsic_data,
  input wire logic                             suspend_enter,
  input wire logic                             clk_stable,
  input wire logic                             remote_wake_active,
  input wire logic                             bus_reset_valid,
  input wire logic                             host_resume_pulse,
  input wire logic                             resuspend_pulse,
  input wire logic [3:0]                       link_state
);
  import hsic_filt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ready; pready; endproperty
  property p_err; pslverr |-> psel && penable; endproperty
  property p_rdata; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  property p_onehot; $onehot(link_state); endproperty
  property p_rst_lvl; bus_reset_valid == (link_state == st_reset); endproperty
  // pins must have shown reset well before the phase entry
  property p_rst_src; $rose(bus_reset_valid) |-> $past({hsic_strobe, hsic_data}, 4) == 2'b00;
  endproperty
  property p_res_dst; host_resume_pulse |-> ##[0:1] link_state == st_active; endproperty
  property p_res_src; host_resume_pulse |-> $past(link_state) inside {st_suspend, st_wake};
  endproperty
  property p_sus_dst; resuspend_pulse |-> ##[0:1] link_state == st_suspend; endproperty
  property p_sus_src; resuspend_pulse |-> $past(link_state) == st_wake; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("pslverr outside access");
  a_rdata: assert property (p_rdata) else $error("read data above byte");
  a_onehot: assert property (p_onehot) else $error("phase not one-hot");
  a_rst_lvl: assert property (p_rst_lvl) else $error("reset flag vs phase");
  a_rst_src: assert property (p_rst_src) else $error("reset without line");
  a_res_dst: assert property (p_res_dst) else $error("resume not active");
  a_res_src: assert property (p_res_src) else $error("resume from wrong phase");
  a_sus_dst: assert property (p_sus_dst) else $error("no return to suspend");
  a_sus_src: assert property (p_sus_src) else $error("idle outside wake");
  c_rst: cover property ($rose(bus_reset_valid));
  c_res: cover property (host_resume_pulse);
  c_sus: cover property (resuspend_pulse);
  c_err: cover property (pslverr);
endmodule : hsic_filt_assertions

/* dv/hsic_host_model.sv */
// Purpose: host side of the hsic link, presents requested line states
// Assumes: lines change only on the host's own 160 ns link clock
// Notes:   idle is shown while reset is held
`timescale 1ns/1ps
module hsic_host_model (
  input  wire logic                       rst,
  input  wire hsic_filt_pkg::line_state_t want,
  output logic                            hsic_strobe,
  output logic                            hsic_data
);
  import hsic_filt_pkg::*;
  logic lclk;
  // pins stay unknown until the first link edge; the bench holds the design in reset until then
  initial begin
    lclk = 1'b0;
  end
  always #80 lclk = ~lclk;
  always @(posedge lclk) begin
    {hsic_strobe, hsic_data} <= rst ? line_idle : want;
  end
endmodule : hsic_host_model

/* dv/tb_top.sv */
// Purpose: self-checking bench for the bus-state qualifier
// Assumes: zero-wait apb slave, host model drives the hsic pins
// Notes:   small limits keep each qualification run short
`timescale 1ns/1ps
module tb_top;
  import hsic_filt_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hsic_strobe;
  logic        hsic_data;
  logic        suspend_enter = 1'b0;
  logic        clk_stable = 1'b0;
  logic        remote_wake_active = 1'b0;
  logic        bus_reset_valid;
  logic        host_resume_pulse;
  logic        resuspend_pulse;
  logic [3:0]  link_state;
  line_state_t want = line_idle;
  int          err_total = 0;
  int          check_count = 0;
  logic [11:0] ra [7] = '{12'h850, 12'h854, 12'h860, 12'h864, 12'h870, 12'h874, 12'h878};
  logic [7:0]  rv [7] = '{8'hb4, 8'h00, 8'hb4, 8'h00, 8'h60, 8'hea, 8'h00};
  logic [31:0] rd;
  logic        er;
  logic [7:0]  v;
  int          lim;
  int          res_seen = 0;
  int          sus_seen = 0;

  always #5 clk = ~clk;

  // one-cycle pulses tallied so each scenario's outcome is counted exactly
  always @(posedge clk) begin
    if (host_resume_pulse === 1'b1) begin
      res_seen <= res_seen + 1;
    end
    if (resuspend_pulse === 1'b1) begin
      sus_seen <= sus_seen + 1;
    end
  end

  hsic_bus_state_filters dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hsic_strobe(hsic_strobe), .hsic_data(hsic_data),
    .suspend_enter(suspend_enter), .clk_stable(clk_stable),
    .remote_wake_active(remote_wake_active), .bus_reset_valid(bus_reset_valid),
    .host_resume_pulse(host_resume_pulse), .resuspend_pulse(resuspend_pulse),
    .link_state(link_state));
  hsic_host_model host_u (.rst(rst), .want(want), .hsic_strobe(hsic_strobe),
    .hsic_data(hsic_data));

  task automatic close_out;
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] msk(input int i);
    return (i == 6) ? 8'hf0 : 8'hff;
  endfunction : msk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // pipeline margin on top of the tick count
  task automatic wait_st(input logic [3:0] s, input int l);
    int n;
    n = 0;
    while (link_state !== s && n < (l * 5) / 3 + 10) begin
      @(posedge clk);
      n++;
    end
    chk({28'h0, link_state}, {28'h0, s});
    chk({31'h0, n >= (l * 5) / 3}, 32'h1);
  endtask : wait_st

  task automatic line(input line_state_t s);
    int n;
    n = 0;
    want <= s;
    while ({hsic_strobe, hsic_data} !== s && n < 40) begin
      @(posedge clk);
      n++;
    end
  endtask : line

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  initial begin
    #100us;
    err_total++;
    close_out();
  end

  initial begin
    v = 8'($urandom(4));
    hold(16);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 8'h00);
      chk(rd, {24'h0, rv[i]});
      v = 8'($urandom);
      apb(1'b1, ra[i], v);
      apb(1'b0, ra[i], 8'h00);
      chk(rd, {24'h0, v & msk(i)});
    end
    apb(1'b0, 12'h900, 8'h00);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 12'h851, 8'h11);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h880, 8'h00);
    chk(rd, {26'h0, line_idle, st_active});
    apb(1'b1, 12'h880, 8'h00);
    chk({31'h0, er}, 32'h1);
    for (int i = 1; i < 7; i++) apb(1'b1, ra[i], (i == 2) ? 8'd30 : (i == 4) ? 8'd50 : 8'h00);
    // short reset burst must not qualify
    apb(1'b1, 12'h850, 8'd40);
    line(line_reset);
    hold(32);
    line(line_idle);
    hold(100);
    chk({28'h0, link_state}, {28'h0, st_active});
    for (int k = 0; k < 3; k++) begin
      lim = 8 + $urandom % 40;
      apb(1'b1, 12'h850, 8'(lim));
      line(line_reset);
      wait_st(st_reset, lim);
      hold(60);
      chk({31'h0, bus_reset_valid}, 32'h1);
      line(line_idle);
      wait_st(st_active, 0);
    end
    suspend_enter <= 1'b1;
    hold(1);
    suspend_enter <= 1'b0;
    wait_st(st_suspend, 0);
    hold(200);
    chk({28'h0, link_state}, {28'h0, st_suspend});
    clk_stable <= 1'b1;
    hold(1);
    clk_stable <= 1'b0;
    wait_st(st_wake, 0);
    wait_st(st_suspend, 50);
    // device-driven wake must not use the resume filter
    remote_wake_active <= 1'b1;
    line(line_resume);
    hold(200);
    chk({28'h0, link_state}, {28'h0, st_suspend});
    remote_wake_active <= 1'b0;
    wait_st(st_active, 30);
    line(line_idle);
    hold(20);
    chk(32'(res_seen), 32'h1);
    chk(32'(sus_seen), 32'h1);
    close_out();
  end
endmodule : tb_top

bind hsic_bus_state_filters hsic_filt_assertions chk_u (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .hsic_strobe(hsic_strobe), .hsic_data(hsic_data),
  .suspend_enter(suspend_enter), .clk_stable(clk_stable),
  .remote_wake_active(remote_wake_active), .bus_reset_valid(bus_reset_valid),
  .host_resume_pulse(host_resume_pulse), .resuspend_pulse(resuspend_pulse),
  .link_state(link_state));
